// [hw/pdt_pkg.sv]
/*
  Shared constants and types for the cable supply and message timers.
  Assumes a single 50 MHz controller clock on both ends of the link.
*/
package pdt_pkg;

  // Link message kinds; a pulse marks the last bit of the EOP
  typedef enum logic [2:0] {
    MSG_GOODCRC,
    MSG_ACCEPT,
    MSG_PS_RDY,
    MSG_DISC_ID,
    MSG_ALERT,
    MSG_OTHER
  } pdt_msg_t;

  localparam int CLK_HZ     = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  localparam int CNT_W  = 32;
  localparam int MS_W   = 16;
  localparam int TRY_W  = 4;
  localparam int SLOT_W = 4;

  // Longest times, rounded down to whole cycles
  localparam int SUPPLY_ON_LIMIT_MS   = 100;
  localparam int SUPPLY_ON_LIMIT_CYC  = SUPPLY_ON_LIMIT_MS * CYC_PER_MS;
  localparam int SUPPLY_OFF_LIMIT_MS  = 25;
  localparam int SUPPLY_OFF_LIMIT_CYC = SUPPLY_OFF_LIMIT_MS * CYC_PER_MS;

  // Least times, rounded up to whole cycles
  localparam int CABLE_GAP_US  = 750;
  localparam int CABLE_GAP_CYC = CABLE_GAP_US * CYC_PER_US;

  // Fixed pick inside the 40 ms to 50 ms range
  localparam int PROBE_PERIOD_MS  = 45;
  localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * CYC_PER_MS;
  localparam logic [TRY_W-1:0] PROBE_MAX_TRIES = 4'h8;

  localparam int ALERT_MAX_PER_WINDOW = 10;
  localparam int ALERT_WINDOW_MS      = 10_000;
  localparam int ALERT_MIN_GAP_MS     = 250;
  localparam int ALERT_BURST_GAP_MS   = 100;
  localparam int ALERT_BURST_MAX      = 2;
  // Even spacing that alone keeps the window count in bounds
  localparam int ALERT_SPACE_MS  = ALERT_WINDOW_MS / ALERT_MAX_PER_WINDOW;
  localparam int ALERT_SPACE_CYC = ALERT_SPACE_MS * CYC_PER_MS;

endpackage

// [hw/pdt_link_if.sv]
/*
  Message link between the port controller and its partner.
  Assumes both ends share one clock; the testbench instantiates it.
*/
`timescale 1ns/1ns
interface pdt_link_if;
  logic             d2p_vld;
  pdt_pkg::pdt_msg_t d2p_typ;
  logic             d2p_cab;
  logic             p2d_vld;
  pdt_pkg::pdt_msg_t p2d_typ;
  logic             p2d_cab;

  modport dev (
    output d2p_vld, d2p_typ, d2p_cab,
    input  p2d_vld, p2d_typ, p2d_cab
  );
  modport ptr (
    input  d2p_vld, d2p_typ, d2p_cab,
    output p2d_vld, p2d_typ, p2d_cab
  );
endinterface

// [hw/pdt_dev_end.sv]
/*
  Port controller end: cable supply watch, cable packet gap, cable
  probing and attention rate limiting, with automatic GoodCRC replies.
  Assumes the partner end on pdt_link_if and a held send request.
*/
// Function
// - Watch timer expires 100 ms without PS_RDY
// - Downstream role starts watch on Accept
// - Upstream role starts watch on GoodCRC
// - Received PS_RDY stops the watch timer
// - Send PS_RDY only with supply on
// - Old supplier turns supply off quickly
// - Cable packets wait 750 us after GoodCRC
// - Retries measure gap from last transmission
// - Probe cable only downstream under contract
// - One identity probe every 45 ms
// - Stop cable traffic after unanswered tries
// - At most ten alerts per window
// - Alerts spaced at least 250 ms
// - One two-alert burst at 100 ms
`timescale 1ns/1ns
module pdt_dev_end
  import pdt_pkg::*;
#(
  parameter int ON_CYC    = SUPPLY_ON_LIMIT_CYC,
  parameter int GAP_CYC   = CABLE_GAP_CYC,
  parameter int PROBE_CYC = PROBE_PERIOD_CYC,
  parameter int MS_CYC    = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  // Link
  pdt_link_if.dev       lnk,
  // Policy requests
  input  wire logic     i_dfp,
  input  wire logic     i_contract,
  input  wire logic     i_supply_on,
  input  wire logic     i_tx_req,
  input  wire pdt_msg_t i_tx_typ,
  input  wire logic     i_tx_cab,
  // Policy status
  output logic          o_tx_ack,
  output logic          o_supply_en,
  output logic          o_watch_run,
  output logic          o_watch_exp,
  output logic          o_gap_busy,
  output logic          o_probe_exp,
  output logic          o_probe_found,
  output logic          o_probe_gave_up,
  output logic          o_alert_ok
);

  function automatic logic [MS_W-1:0] age(input logic [MS_W-1:0] stamp,
                                          input logic [MS_W-1:0] now);
    age = now - stamp;
  endfunction

  logic             tx_vld_q, tx_cab_q, ack_q, supply_q, acc_sent_q;
  pdt_msg_t         tx_typ_q;
  logic             watch_run_q, watch_exp_q, gap_run_q;
  logic [CNT_W-1:0] watch_cnt_q, gap_cnt_q, probe_cnt_q, div_cnt_q;
  logic             probe_pend_q, probe_exp_q, found_q, gave_up_q;
  logic [TRY_W-1:0] tries_q;
  logic [MS_W-1:0]  now_q, last_q, burst_q;
  logic             last_vld_q, burst_vld_q, alert_ok_q;
  logic [SLOT_W-1:0] wr_q;
  wire  logic [ALERT_MAX_PER_WINDOW-1:0] used;

  // Receive decode
  wire logic rx_gcrc  = lnk.p2d_vld && lnk.p2d_typ == MSG_GOODCRC;
  wire logic rx_acc   = lnk.p2d_vld && lnk.p2d_typ == MSG_ACCEPT;
  wire logic rx_psr   = lnk.p2d_vld && lnk.p2d_typ == MSG_PS_RDY;
  wire logic rx_gcab  = rx_gcrc && lnk.p2d_cab;
  wire logic reply    = lnk.p2d_vld && lnk.p2d_typ != MSG_GOODCRC;

  // Watch timer
  wire logic watch_start = i_dfp ? rx_acc
                                 : rx_gcrc && acc_sent_q;
  wire logic watch_end = watch_run_q &&
                         watch_cnt_q == CNT_W'(ON_CYC - 1);

  // Cable traffic gating
  wire logic cab_ok   = !gap_run_q && !gave_up_q;
  wire logic gap_end  = gap_run_q && gap_cnt_q == CNT_W'(GAP_CYC - 1);

  // Probe timer
  wire logic probe_act  = i_dfp && i_contract &&
                          !gave_up_q && !found_q;
  wire logic probe_wrap = probe_act &&
                          probe_cnt_q == CNT_W'(PROBE_CYC - 1);
  wire logic probe_go   = probe_pend_q && cab_ok && !reply;
  wire logic at_max     = tries_q == PROBE_MAX_TRIES;

  // Attention limiter
  wire logic            tick  = div_cnt_q == CNT_W'(MS_CYC - 1);
  wire logic [MS_W-1:0] since = age(last_q, now_q);
  // Ages compare with > since a stamp may sit late in its tick
  wire logic gap_ok   = !last_vld_q ||
                        since > MS_W'(ALERT_MIN_GAP_MS);
  wire logic burst_ok = !burst_vld_q &&
                        since > MS_W'(ALERT_BURST_GAP_MS);
  // Round-robin slots: the next slot is the oldest entry
  wire logic alert_ok = !used[wr_q] && (gap_ok || burst_ok);

  // Send selection; GoodCRC replies go first, then the probe
  wire logic user_ok = i_tx_req && !reply && !probe_go &&
                       (!i_tx_cab || cab_ok) &&
                       (i_tx_typ != MSG_PS_RDY || supply_q) &&
                       (i_tx_typ != MSG_ALERT || alert_ok);
  wire logic     tx_vld_d = reply || probe_go || user_ok;
  wire pdt_msg_t tx_typ_d = reply ? MSG_GOODCRC :
                            probe_go ? MSG_DISC_ID : i_tx_typ;
  wire logic     tx_cab_d = reply ? lnk.p2d_cab : (probe_go || i_tx_cab);
  wire logic     tx_cpkt  = tx_vld_d && tx_cab_d && tx_typ_d != MSG_GOODCRC;
  wire logic     alert_fire = user_ok && i_tx_typ == MSG_ALERT;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_vld_q   <= 1'b0;
      tx_typ_q   <= MSG_OTHER;
      tx_cab_q   <= 1'b0;
      ack_q      <= 1'b0;
      supply_q   <= 1'b0;
      acc_sent_q <= 1'b0;
    end else begin
      tx_vld_q <= tx_vld_d;
      tx_typ_q <= tx_typ_d;
      tx_cab_q <= tx_cab_d;
      ack_q    <= user_ok;
      if (rx_psr && supply_q) begin
        supply_q <= 1'b0;
      end else if (i_supply_on) begin
        supply_q <= 1'b1;
      end
      if (tx_vld_d && tx_typ_d == MSG_ACCEPT) begin
        acc_sent_q <= 1'b1;
      end else if (rx_gcrc) begin
        acc_sent_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      watch_run_q <= 1'b0;
      watch_cnt_q <= '0;
      watch_exp_q <= 1'b0;
    end else begin
      // PS_RDY on the last count still counts as in time
      watch_exp_q <= watch_end && !rx_psr;
      if (rx_psr) begin
        watch_run_q <= 1'b0;
      end else if (watch_start) begin
        watch_run_q <= 1'b1;
        watch_cnt_q <= '0;
      end else if (watch_end) begin
        watch_run_q <= 1'b0;
      end else if (watch_run_q) begin
        watch_cnt_q <= watch_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gap_run_q <= 1'b0;
      gap_cnt_q <= '0;
    end else if (rx_gcab || tx_cpkt) begin
      gap_run_q <= 1'b1;
      gap_cnt_q <= '0;
    end else if (gap_end) begin
      gap_run_q <= 1'b0;
    end else if (gap_run_q) begin
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      probe_cnt_q  <= '0;
      probe_pend_q <= 1'b0;
      probe_exp_q  <= 1'b0;
      tries_q      <= '0;
      found_q      <= 1'b0;
      gave_up_q    <= 1'b0;
    end else begin
      probe_exp_q <= probe_wrap;
      if (!probe_act) begin
        probe_cnt_q  <= '0;
        probe_pend_q <= 1'b0;
      end else begin
        probe_cnt_q  <= probe_wrap ? '0 : probe_cnt_q + 1'b1;
        probe_pend_q <= (probe_pend_q && !probe_go) ||
                        (probe_wrap && !at_max);
      end
      if (rx_gcab && tries_q != '0) begin
        tries_q <= '0;
        found_q <= 1'b1;
      end else if (probe_go) begin
        tries_q <= tries_q + 1'b1;
      end
      // Last try had a whole period to be answered
      if (probe_wrap && at_max && !rx_gcab) begin
        gave_up_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt_q <= '0;
      now_q     <= '0;
    end else begin
      div_cnt_q <= tick ? '0 : div_cnt_q + 1'b1;
      if (tick) begin
        now_q <= now_q + 1'b1;
      end
    end
  end

  generate
    for (genvar i = 0; i < ALERT_MAX_PER_WINDOW; i++) begin : g_slot
      logic            vld_q;
      logic [MS_W-1:0] stamp_q;
      assign used[i] = vld_q;
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          vld_q   <= 1'b0;
          stamp_q <= '0;
        end else if (alert_fire && wr_q == SLOT_W'(i)) begin
          vld_q   <= 1'b1;
          stamp_q <= now_q;
        end else if (tick &&
                     age(stamp_q, now_q) > MS_W'(ALERT_WINDOW_MS)) begin
          vld_q   <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q        <= '0;
      last_q      <= '0;
      last_vld_q  <= 1'b0;
      burst_q     <= '0;
      burst_vld_q <= 1'b0;
      alert_ok_q  <= 1'b0;
    end else begin
      alert_ok_q <= alert_ok;
      if (alert_fire) begin
        wr_q <= (wr_q == SLOT_W'(ALERT_MAX_PER_WINDOW - 1)) ?
                '0 : wr_q + 1'b1;
        last_q     <= now_q;
        last_vld_q <= 1'b1;
      end else if (tick && since > MS_W'(ALERT_WINDOW_MS)) begin
        last_vld_q <= 1'b0;
      end
      if (alert_fire && !gap_ok) begin
        burst_q     <= now_q;
        burst_vld_q <= 1'b1;
      end else if (tick &&
                   age(burst_q, now_q) > MS_W'(ALERT_WINDOW_MS)) begin
        burst_vld_q <= 1'b0;
      end
    end
  end

  assign lnk.d2p_vld     = tx_vld_q;
  assign lnk.d2p_typ     = tx_typ_q;
  assign lnk.d2p_cab     = tx_cab_q;
  assign o_tx_ack        = ack_q;
  assign o_supply_en     = supply_q;
  assign o_watch_run     = watch_run_q;
  assign o_watch_exp     = watch_exp_q;
  assign o_gap_busy      = gap_run_q;
  assign o_probe_exp     = probe_exp_q;
  assign o_probe_found   = found_q;
  assign o_probe_gave_up = gave_up_q;
  assign o_alert_ok      = alert_ok_q;

endmodule // pdt_dev_end

// [hw/pdt_ptr_end.sv]
/*
  Partner end: port partner or cable plug sending messages to the
  controller, with its own supply, cable gap and attention spacing.
  Assumes the controller end on pdt_link_if and a held send request.
*/
`timescale 1ns/1ns
module pdt_ptr_end
  import pdt_pkg::*;
#(
  parameter int GAP_CYC   = CABLE_GAP_CYC,
  parameter int SPACE_CYC = ALERT_SPACE_CYC
) (
  // Clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  // Link
  pdt_link_if.ptr       lnk,
  // Partner requests
  input  wire logic     i_ack_en,
  input  wire logic     i_supply_on,
  input  wire logic     i_tx_req,
  input  wire pdt_msg_t i_tx_typ,
  input  wire logic     i_tx_cab,
  // Partner status
  output logic          o_tx_ack,
  output logic          o_supply_en,
  output logic          o_rx_vld,
  output pdt_msg_t      o_rx_typ,
  output logic          o_rx_cab
);

  logic             tx_vld_q, tx_cab_q, ack_q, supply_q;
  pdt_msg_t         tx_typ_q, rx_typ_q;
  logic             rx_vld_q, rx_cab_q, gap_run_q, spc_run_q;
  logic [CNT_W-1:0] gap_cnt_q, spc_cnt_q;

  wire logic rx_gcrc = lnk.d2p_vld && lnk.d2p_typ == MSG_GOODCRC;
  wire logic rx_psr  = lnk.d2p_vld && lnk.d2p_typ == MSG_PS_RDY;
  // Clearing i_ack_en lets a test starve the probe of answers
  wire logic reply   = i_ack_en && lnk.d2p_vld &&
                       lnk.d2p_typ != MSG_GOODCRC;
  wire logic gap_end = gap_run_q && gap_cnt_q == CNT_W'(GAP_CYC - 1);
  wire logic spc_end = spc_run_q && spc_cnt_q == CNT_W'(SPACE_CYC - 1);

  wire logic user_ok = i_tx_req && !reply &&
                       (!i_tx_cab || !gap_run_q) &&
                       (i_tx_typ != MSG_PS_RDY || supply_q) &&
                       (i_tx_typ != MSG_ALERT || !spc_run_q);
  wire logic     tx_vld_d = reply || user_ok;
  wire pdt_msg_t tx_typ_d = reply ? MSG_GOODCRC : i_tx_typ;
  wire logic     tx_cab_d = reply ? lnk.d2p_cab : i_tx_cab;
  wire logic     tx_cpkt  = user_ok && i_tx_cab;
  wire logic     alert_go = user_ok && i_tx_typ == MSG_ALERT;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_vld_q <= 1'b0;
      tx_typ_q <= MSG_OTHER;
      tx_cab_q <= 1'b0;
      ack_q    <= 1'b0;
      supply_q <= 1'b0;
      rx_vld_q <= 1'b0;
      rx_typ_q <= MSG_OTHER;
      rx_cab_q <= 1'b0;
    end else begin
      tx_vld_q <= tx_vld_d;
      tx_typ_q <= tx_typ_d;
      tx_cab_q <= tx_cab_d;
      ack_q    <= user_ok;
      rx_vld_q <= lnk.d2p_vld;
      rx_typ_q <= lnk.d2p_typ;
      rx_cab_q <= lnk.d2p_cab;
      if (rx_psr && supply_q) begin
        supply_q <= 1'b0;
      end else if (i_supply_on) begin
        supply_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gap_run_q <= 1'b0;
      gap_cnt_q <= '0;
    end else if ((rx_gcrc && lnk.d2p_cab) || tx_cpkt) begin
      gap_run_q <= 1'b1;
      gap_cnt_q <= '0;
    end else if (gap_end) begin
      gap_run_q <= 1'b0;
    end else if (gap_run_q) begin
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  // Even spacing of window over count: never bursts, never over count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      spc_run_q <= 1'b0;
      spc_cnt_q <= '0;
    end else if (alert_go) begin
      spc_run_q <= 1'b1;
      spc_cnt_q <= '0;
    end else if (spc_end) begin
      spc_run_q <= 1'b0;
    end else if (spc_run_q) begin
      spc_cnt_q <= spc_cnt_q + 1'b1;
    end
  end

  assign lnk.p2d_vld = tx_vld_q;
  assign lnk.p2d_typ = tx_typ_q;
  assign lnk.p2d_cab = tx_cab_q;
  assign o_tx_ack    = ack_q;
  assign o_supply_en = supply_q;
  assign o_rx_vld    = rx_vld_q;
  assign o_rx_typ    = rx_typ_q;
  assign o_rx_cab    = rx_cab_q;

endmodule // pdt_ptr_end

// [testbench/pdt_link_monitor.sv]
/*
  Link checker: replies, cable gaps, probe tries and alert spacing.
  Assumes one clock and both ends joined by pdt_link_if.
*/
`timescale 1ns/1ns
module pdt_link_monitor
  import pdt_pkg::*;
#(
  parameter int GAP_CYC   = CABLE_GAP_CYC,
  parameter int SPACE_CYC = ALERT_SPACE_CYC,
  parameter int MS_CYC    = CYC_PER_MS
) (
  // Clock and reset
  input wire logic     i_clk,
  input wire logic     i_rst,
  // Link
  input wire logic     d2p_vld,
  input wire pdt_msg_t d2p_typ,
  input wire logic     d2p_cab,
  input wire logic     p2d_vld,
  input wire pdt_msg_t p2d_typ,
  input wire logic     p2d_cab
);
  localparam int BURST_CYC = ALERT_BURST_GAP_MS * MS_CYC;
  localparam int MIN_CYC   = ALERT_MIN_GAP_MS * MS_CYC;

  // Ages saturate so an idle link never wraps into a false gap
  logic [CNT_W-1:0] dgap_q, pgap_q, dal_q, pal_q;
  logic [TRY_W-1:0] tries_q;
  logic             short_q;
  wire d_cs = d2p_vld && d2p_cab && d2p_typ != MSG_GOODCRC;
  wire p_cs = p2d_vld && p2d_cab && p2d_typ != MSG_GOODCRC;
  wire d_gc = d2p_vld && d2p_cab && d2p_typ == MSG_GOODCRC;
  wire p_gc = p2d_vld && p2d_cab && p2d_typ == MSG_GOODCRC;
  wire d_al = d2p_vld && d2p_typ == MSG_ALERT;
  wire p_al = p2d_vld && p2d_typ == MSG_ALERT;
  wire d_pr = d2p_vld && d2p_cab && d2p_typ == MSG_DISC_ID;

  function automatic logic [CNT_W-1:0] age(input logic             ev,
                                           input logic [CNT_W-1:0] q);
    return ev ? '0 : (&q ? q : q + 1'b1);
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {dgap_q, pgap_q, dal_q, pal_q} <= '1;
      tries_q <= '0;
      short_q <= 1'b0;
    end else begin
      dgap_q  <= age(p_gc || d_cs, dgap_q);
      pgap_q  <= age(d_gc || p_cs, pgap_q);
      dal_q   <= age(d_al, dal_q);
      pal_q   <= age(p_al, pal_q);
      tries_q <= p_gc ? '0 : tries_q + {{(TRY_W-1){1'b0}}, d_pr};
      short_q <= d_al ? (dal_q < CNT_W'(MIN_CYC - 1)) : short_q;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_DEV_REPLY: assert property (
    p2d_vld && p2d_typ != MSG_GOODCRC |=> d2p_vld
      && d2p_typ == MSG_GOODCRC && d2p_cab == $past(p2d_cab))
    else $error("controller reply missing");
  AST_PTR_REPLY: assert property (
    p2d_vld && p2d_typ == MSG_GOODCRC |-> $past(d2p_vld)
      && $past(d2p_typ) != MSG_GOODCRC && p2d_cab == $past(d2p_cab))
    else $error("partner reply without cause");
  AST_DEV_GAP: assert property (d_cs |-> dgap_q >= GAP_CYC - 1)
    else $error("controller cable gap short");
  AST_PTR_GAP: assert property (p_cs |-> pgap_q >= GAP_CYC - 1)
    else $error("partner cable gap short");
  AST_PROBE_TRIES: assert property (
    d_cs |-> tries_q < PROBE_MAX_TRIES)
    else $error("cable send after unanswered probes");
  AST_ALERT_BURST: assert property (d_al |-> dal_q >= BURST_CYC - 1)
    else $error("alert burst spacing short");
  AST_ALERT_SPACE: assert property (
    d_al && short_q |-> dal_q >= MIN_CYC - 1)
    else $error("second alert burst");
  AST_PTR_ALERT: assert property (p_al |-> pal_q >= SPACE_CYC - 1)
    else $error("partner alert spacing short");
endmodule // pdt_link_monitor

// [testbench/pd_cable_supply_and_message_timers_tb_top.sv]
/*
  Testbench for the timer block: controller and partner ends joined.
  Assumes design files and the link checker are compiled first.
*/
`timescale 1ns/1ns
module pd_cable_supply_and_message_timers_tb_top;
  import pdt_pkg::*;
  // Short counts keep the run small
  localparam int ON = 50, GAP = 20, PRB = 100, MS = 4;
  localparam int SPC = ALERT_SPACE_MS * MS;

  logic     i_clk = 1'b0;
  logic     i_rst = 1'b1;
  logic     dfp = 1'b0, con = 1'b0, d_son = 1'b0, d_req = 1'b0;
  logic     d_cab = 1'b0, p_ack_en = 1'b1, p_son = 1'b0, p_req = 1'b0;
  logic     p_cab = 1'b0;
  pdt_msg_t d_typ = MSG_OTHER, p_typ = MSG_OTHER;
  logic     d_ack, d_sup, run, wexp, gbusy, pexp, found, gave, aok, p_ack;
  logic     p_sup, prv, prc;
  pdt_msg_t prt;
  int       n_mismatch = 0, tests_run = 0, n_disc = 0;

  pdt_link_if lnk ();
  always #10 i_clk = ~i_clk;

  pdt_dev_end #(.ON_CYC(ON), .GAP_CYC(GAP), .PROBE_CYC(PRB), .MS_CYC(MS))
  i_pdt_dev_end (
    .i_clk(i_clk), .i_rst(i_rst), .lnk(lnk.dev), .i_dfp(dfp),
    .i_contract(con), .i_supply_on(d_son), .i_tx_req(d_req),
    .i_tx_typ(d_typ), .i_tx_cab(d_cab), .o_tx_ack(d_ack),
    .o_supply_en(d_sup), .o_watch_run(run), .o_watch_exp(wexp),
    .o_gap_busy(gbusy), .o_probe_exp(pexp), .o_probe_found(found),
    .o_probe_gave_up(gave), .o_alert_ok(aok));
  pdt_ptr_end #(.GAP_CYC(GAP), .SPACE_CYC(SPC)) i_pdt_ptr_end (
    .i_clk(i_clk), .i_rst(i_rst), .lnk(lnk.ptr), .i_ack_en(p_ack_en),
    .i_supply_on(p_son), .i_tx_req(p_req), .i_tx_typ(p_typ),
    .i_tx_cab(p_cab), .o_tx_ack(p_ack), .o_supply_en(p_sup),
    .o_rx_vld(prv), .o_rx_typ(prt), .o_rx_cab(prc));
  pdt_link_monitor #(.GAP_CYC(GAP), .SPACE_CYC(SPC), .MS_CYC(MS))
  i_pdt_link_monitor (
    .i_clk(i_clk), .i_rst(i_rst), .d2p_vld(lnk.d2p_vld),
    .d2p_typ(lnk.d2p_typ), .d2p_cab(lnk.d2p_cab), .p2d_vld(lnk.p2d_vld),
    .p2d_typ(lnk.p2d_typ), .p2d_cab(lnk.p2d_cab));

  // Single owner of the probe count; reset clears it
  always @(posedge i_clk) begin
    if (i_rst) begin
      n_disc <= 0;
    end else if (lnk.d2p_vld === 1'b1 && lnk.d2p_typ === MSG_DISC_ID) begin
      n_disc <= n_disc + 1;
    end
  end

  function automatic int alert_gap(input bit burst);
    return (burst ? ALERT_BURST_GAP_MS : ALERT_MIN_GAP_MS) * MS;
  endfunction

  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic rst();
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({d_ack, d_sup, run, wexp, gbusy, pexp, found, gave, p_sup, prv}
        === 10'h0, "reset");
    i_rst = 1'b0;
  endtask

  // Idle edge first, so back-to-back calls never retoggle a request
  task automatic send(input bit dv, input pdt_msg_t t, input logic c,
                      input int lim, output bit ok, output int w);
    @(negedge i_clk);
    {d_typ, p_typ, d_cab, p_cab} = {t, t, c, c};
    d_req = dv;
    p_req = !dv;
    w = 1;
    do begin
      @(negedge i_clk);
      w++;
      ok = dv ? d_ack === 1'b1 : p_ack === 1'b1;
    end while (!ok && w < lim);
    d_req = 1'b0;
    p_req = 1'b0;
  endtask

  initial begin
    int  w, n;
    bit  ok, dv, c;
    time tl [2];
    time t0;
    w = $urandom(32'h14623323);
    rst();
    dfp = 1'b1;
    send(0, MSG_ACCEPT, 1'b0, 10, ok, w);
    @(negedge i_clk);
    chk(run === 1'b1, "watch idle after accept");
    for (n = 1; n < ON + 5 && wexp !== 1'b1; n++) @(negedge i_clk);
    chk(n >= ON - 1 && n <= ON + 2, "watch expiry time");
    @(negedge i_clk);
    chk(wexp === 1'b0 && run === 1'b0, "expiry not one pulse");
    rst();
    d_son = 1'b1;
    send(0, MSG_ACCEPT, 1'b0, 10, ok, w);
    d_son = 1'b0;
    send(0, MSG_PS_RDY, 1'b0, 10, ok, w);
    chk(!ok && run === 1'b1 && d_sup === 1'b1, "ps_rdy unpowered");
    p_son = 1'b1;
    send(0, MSG_PS_RDY, 1'b0, 10, ok, w);
    repeat (2) @(negedge i_clk);
    chk(d_sup === 1'b0, "old supplier still on");
    for (n = 0; n < ON + 5 && wexp !== 1'b1 && run !== 1'b1; n++) @(negedge i_clk);
    chk(n == ON + 5, "watch not stopped");
    rst();
    dfp = 1'b0;
    send(0, MSG_ACCEPT, 1'b0, 10, ok, w);
    repeat (3) @(negedge i_clk);
    chk(run === 1'b0, "watch started on accept as ufp");
    send(1, MSG_PS_RDY, 1'b0, 10, ok, w);
    chk(!ok, "own ps_rdy unpowered");
    send(1, MSG_ACCEPT, 1'b0, 10, ok, w);
    repeat (3) @(negedge i_clk);
    chk(run === 1'b1, "watch idle after goodcrc");
    p_son = 1'b0;
    d_son = 1'b1;
    send(1, MSG_PS_RDY, 1'b0, 10, ok, w);
    @(negedge i_clk);
    chk(ok && prv === 1'b1 && prt === MSG_PS_RDY && prc === 1'b0,
        "own ps_rdy not seen");
    chk(p_sup === 1'b0 && d_sup === 1'b1, "partner supply still on");
    d_son = 1'b0;
    rst();
    dfp = 1'b1;
    p_ack_en = 1'b0;
    repeat (3 * PRB) @(negedge i_clk);
    chk(n_disc == 0, "probe without contract");
    con = 1'b1;
    for (n = 0; n < 2 * PRB && pexp !== 1'b1; n++) @(negedge i_clk);
    @(negedge i_clk);
    for (n = 1; n < 2 * PRB && pexp !== 1'b1; n++) @(negedge i_clk);
    chk(n == PRB, "probe period");
    for (n = 0; n < 12 * PRB && gave !== 1'b1; n++) @(negedge i_clk);
    chk(gave === 1'b1 && n_disc == PROBE_MAX_TRIES, "probe give up");
    send(1, MSG_OTHER, 1'b1, 3 * GAP, ok, w);
    chk(!ok, "cable send after give up");
    rst();
    p_ack_en = 1'b1;
    for (n = 0; n < 3 * PRB && found !== 1'b1; n++) @(negedge i_clk);
    repeat (3 * PRB) @(negedge i_clk);
    chk(found === 1'b1 && n_disc == 1, "probing after found");
    con = 1'b0;
    rst();
    tl = '{0, 0};
    repeat (16) begin
      dv = 1'($urandom_range(1, 0));
      c = 1'($urandom_range(1, 0));
      repeat ($urandom_range(2, 0)) @(negedge i_clk);
      send(dv, MSG_OTHER, c, 4 * GAP, ok, w);
      if (c) begin
        chk(ok && (tl[dv] == 0 || ($time - tl[dv]) / 20 >= GAP), "gap");
        tl[dv] = $time;
      end
    end
    rst();
    repeat (2) @(negedge i_clk);
    chk(aok === 1'b1, "alert blocked after reset");
    send(1, MSG_ALERT, 1'b0, 10, ok, w);
    t0 = $time;
    send(1, MSG_ALERT, 1'b0, 3 * alert_gap(0), ok, w);
    chk(ok && w >= alert_gap(1) && w < alert_gap(0), "burst");
    send(1, MSG_ALERT, 1'b0, 3 * alert_gap(0), ok, w);
    chk(ok && w >= alert_gap(0), "spacing after burst");
    repeat (7) begin
      send(1, MSG_ALERT, 1'b0, 3 * alert_gap(0), ok, w);
      chk(ok && w >= alert_gap(0), "alert spacing");
    end
    send(1, MSG_ALERT, 1'b0, 12 * ALERT_WINDOW_MS / 10 * MS, ok, w);
    chk(ok && ($time - t0) / 20 >= ALERT_WINDOW_MS * MS, "window");
    send(0, MSG_ALERT, 1'b0, 10, ok, w);
    send(0, MSG_ALERT, 1'b0, 3 * SPC, ok, w);
    chk(ok && w >= SPC, "partner alert spacing");
    give_verdict();
  end
endmodule // pd_cable_supply_and_message_timers_tb_top
